/* File: aar_alert_port.sv */
// per-port asynchronous alert builder, queue and retry sender
`timescale 1ns/1ps
// Overview of operation
// - alerts are sent with message code 04h
// - tag comes from latest port configuration
// - alert code is type, subtype, info bytes
// - control byte copied from triggering frame
// - channel copied from triggering frame
// - frame data copied, at most 21 bytes
// - frame fields only meaningful for frame alerts
// - address copied from configured path, no padding
// - only a reply with matching tag acknowledges
// - link recovery exit dropped if same port
// - every other alert type is always reported
// - alert stays pending until its reply arrives
// - resend after 500 ms without reply
// - resend forever until reply or reset
// - replies with nothing pending are discarded
// - all alerts use the single configured tag
// - one alert outstanding, others wait queued
// - messages leave only through the dequeue step
// - meaning is all three code bytes together
module aar_alert_port #(
  parameter int          QUEUE_DEPTH  = aar_pkg::QUEUE_DEPTH_DEF,
  parameter int          ADDR_MAX     = aar_pkg::ADDR_MAX_DEF,
  parameter logic [7:0]  PORT_NUM     = 8'h00,
  parameter int unsigned RETRY_CYCLES = aar_pkg::RETRY_CYCLES
) (
  // clock and reset
  input  wire logic                                ref_clk_i,
  input  wire logic                                rst_n_i,
  // protocol resets
  input  wire logic                                total_reset_i,
  input  wire logic                                absolute_reset_i,
  // port configuration
  input  wire logic                                cfg_valid_i,
  input  wire logic [15:0]                         cfg_tag_i,
  input  wire logic [ADDR_MAX*8-1:0]               cfg_path_i,
  input  wire logic [7:0]                          cfg_path_len_i,
  // alert requests
  input  wire logic                                alert_valid_i,
  output logic                                     alert_ready_o,
  input  wire logic [aar_pkg::ALERT_W-1:0]         alert_code_i,
  input  wire logic                                alert_has_frame_i,
  input  wire logic [7:0]                          alert_ctrl_i,
  input  wire logic [aar_pkg::CHAN_W-1:0]          alert_chan_i,
  input  wire logic [aar_pkg::FRAME_DATA_MAX*8-1:0] alert_data_i,
  input  wire logic [7:0]                          alert_len_i,
  input  wire logic                                alert_erp_exit_i,
  input  wire logic [7:0]                          alert_src_port_i,
  input  wire logic [7:0]                          alert_tx_port_i,
  // replies from the master
  input  wire logic                                reply_valid_i,
  input  wire logic [15:0]                         reply_tag_i,
  // outgoing message bytes
  output logic                                     tx_valid_o,
  output logic [7:0]                               tx_data_o,
  output logic                                     tx_first_o,
  output logic                                     tx_last_o,
  input  wire logic                                tx_ready_i,
  // status
  output logic                                     pending_o,
  output logic                                     erp_drop_o,
  output logic                                     reply_drop_o
);
  import aar_pkg::*;

  localparam int QAW = $clog2(QUEUE_DEPTH);
  localparam int AIW = $clog2(ADDR_MAX);

  // ************************************************************
  // state
  // ************************************************************
  aar_state_t                      state_q, state_d;
  logic [15:0]                     cfg_tag_q;
  logic [ADDR_MAX-1:0][7:0]        cfg_path_q;
  logic [7:0]                      cfg_alen_q;
  logic                            cfg_seen_q;
  logic [15:0]                     msg_tag_q;
  logic [ADDR_MAX-1:0][7:0]        msg_addr_q;
  logic [7:0]                      msg_alen_q;
  logic [ALERT_W-1:0]              msg_alert_q;
  logic [7:0]                      msg_ctrl_q;
  logic [CHAN_W-1:0]               msg_chan_q;
  logic [FRAME_DATA_MAX-1:0][7:0]  msg_data_q;
  logic [LEN_W-1:0]                msg_dlen_q;
  logic [7:0]                      idx_q;
  logic [QAW-1:0]                  wr_ptr_q, rd_ptr_q;
  logic [QAW:0]                    count_q, count_d;
  logic                            pending_q, pending_d;
  logic                            tmr_expire;

  aar_mem_if #(.W(ENT_W), .AW(QAW)) mem_if ();

  aar_queue_mem #(.W(ENT_W), .DEPTH(QUEUE_DEPTH)) u_queue (
    .ref_clk_i (ref_clk_i),
    .m         (mem_if)
  );

  // ************************************************************
  // request decode
  // ************************************************************
  wire             flush      = total_reset_i | absolute_reset_i;
  wire             accept     = alert_valid_i & alert_ready_o;
  wire             erp_same   = alert_erp_exit_i && (alert_src_port_i == alert_tx_port_i);
  wire             push       = accept & ~erp_same & ~flush;
  wire             pop        = (state_q == AAR_IDLE) && (count_q != '0) && cfg_seen_q && !flush;
  wire             ack        = reply_valid_i && pending_q && (reply_tag_i == msg_tag_q);
  wire             tx_adv     = !tx_valid_o || tx_ready_i;
  wire [7:0]       cfg_alen   = (cfg_path_len_i > 8'(ADDR_MAX)) ? 8'(ADDR_MAX) : cfg_path_len_i;
  wire [LEN_W-1:0] data_cap   = (alert_len_i > 8'(FRAME_DATA_MAX)) ? LEN_W'(FRAME_DATA_MAX) : alert_len_i[LEN_W-1:0];
  // frame fields capped, zeroed without a frame
  wire [LEN_W-1:0]              ent_len   = alert_has_frame_i ? data_cap : '0;
  wire [FRAME_DATA_MAX*8-1:0]   ent_data  = alert_has_frame_i ? alert_data_i : '0;
  wire [7:0]                    ent_ctrl  = alert_has_frame_i ? alert_ctrl_i : '0;
  wire [CHAN_W-1:0]             ent_chan  = alert_has_frame_i ? alert_chan_i : '0;

  // queue memory connections
  assign mem_if.wr_en   = push;
  assign mem_if.wr_addr = wr_ptr_q;
  assign mem_if.wr_data = {ent_len, ent_data, ent_chan, ent_ctrl, alert_code_i};
  assign mem_if.rd_en   = pop;
  assign mem_if.rd_addr = rd_ptr_q;

  // ************************************************************
  // byte selection
  // ************************************************************
  logic [HDR_BYTES-1:0][7:0] hdr_w;
  assign hdr_w = {msg_chan_q[7:0], msg_chan_q[15:8], msg_ctrl_q, RSVD_BYTE, msg_alert_q[7:0],
                  msg_alert_q[15:8], msg_alert_q[23:16], msg_tag_q[7:0], msg_tag_q[15:8], PORT_NUM,
                  SMS_ASYNC_ALERT};

  wire [7:0] hdr_idx   = idx_q - msg_alen_q;
  wire [7:0] data_idx  = hdr_idx - 8'(HDR_BYTES);
  wire [7:0] total     = msg_alen_q + 8'(HDR_BYTES) + {3'h0, msg_dlen_q};
  wire       is_last   = (idx_q == total - 8'h01);
  wire       in_addr   = (idx_q < msg_alen_q);
  wire       in_hdr    = (hdr_idx < 8'(HDR_BYTES));
  wire [7:0] next_byte = in_addr ? msg_addr_q[idx_q[AIW-1:0]] :
                         in_hdr  ? hdr_w[hdr_idx[3:0]] : msg_data_q[data_idx[4:0]];

  // ************************************************************
  // sender control
  // ************************************************************
  // pending until matching reply
  always_comb begin
    pending_d = pending_q;
    if (flush || ack) begin
      pending_d = 1'b0;
    end else if (state_q == AAR_LOAD) begin
      pending_d = 1'b1;
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      AAR_IDLE: begin
        if (pop) begin
          state_d = AAR_LOAD;
        end
      end
      AAR_LOAD:  state_d = flush ? AAR_IDLE : AAR_SEND;
      AAR_SEND: begin
        if (tx_adv && is_last) begin
          state_d = AAR_DRAIN;
        end
      end
      AAR_DRAIN: begin
        if (tx_ready_i) begin
          state_d = pending_d ? AAR_WAIT : AAR_IDLE;
        end
      end
      AAR_WAIT: begin
        if (!pending_d) begin
          state_d = AAR_IDLE;
        end else if (tmr_expire) begin
          state_d = AAR_SEND;
        end
      end
      default:   state_d = AAR_IDLE;
    endcase
  end

  aar_retry_timer #(.CYCLES(RETRY_CYCLES)) u_timer (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .start_i   (state_q == AAR_DRAIN && tx_ready_i && pending_d),
    .stop_i    (!pending_d),
    .expire_o  (tmr_expire)
  );

  always_comb begin
    count_d = flush ? '0 : count_q + {{QAW{1'b0}}, push} - {{QAW{1'b0}}, pop};
  end

  // state, queue pointers and status flops
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state_q       <= AAR_IDLE;
      wr_ptr_q      <= '0;
      rd_ptr_q      <= '0;
      count_q       <= '0;
      pending_q     <= 1'b0;
      alert_ready_o <= 1'b0;
      erp_drop_o    <= 1'b0;
      reply_drop_o  <= 1'b0;
    end else begin
      state_q       <= state_d;
      wr_ptr_q      <= flush ? '0 : wr_ptr_q + QAW'(push);
      rd_ptr_q      <= flush ? '0 : rd_ptr_q + QAW'(pop);
      count_q       <= count_d;
      pending_q     <= pending_d;
      alert_ready_o <= (count_d < (QAW+1)'(QUEUE_DEPTH));
      erp_drop_o    <= accept & erp_same;
      reply_drop_o  <= reply_valid_i & ~ack;
    end
  end
  assign pending_o = pending_q;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cfg_tag_q  <= TAG_RST;
      cfg_path_q <= '0;
      cfg_alen_q <= '0;
      cfg_seen_q <= 1'b0;
    end else if (cfg_valid_i) begin
      cfg_tag_q  <= cfg_tag_i;
      cfg_path_q <= cfg_path_i;
      cfg_alen_q <= cfg_alen;
      cfg_seen_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      msg_tag_q   <= TAG_RST;
      msg_addr_q  <= '0;
      msg_alen_q  <= '0;
      msg_alert_q <= '0;
      msg_ctrl_q  <= '0;
      msg_chan_q  <= '0;
      msg_data_q  <= '0;
      msg_dlen_q  <= '0;
    end else if (state_q == AAR_LOAD) begin
      msg_tag_q   <= cfg_tag_q;
      msg_addr_q  <= cfg_path_q;
      msg_alen_q  <= cfg_alen_q;
      msg_alert_q <= mem_if.rd_data[ENT_ALERT_LSB +: ALERT_W];
      msg_ctrl_q  <= mem_if.rd_data[ENT_CTRL_LSB +: 8];
      msg_chan_q  <= mem_if.rd_data[ENT_CHAN_LSB +: CHAN_W];
      msg_data_q  <= mem_if.rd_data[ENT_DATA_LSB +: FRAME_DATA_MAX*8];
      msg_dlen_q  <= mem_if.rd_data[ENT_LEN_LSB +: LEN_W];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      idx_q <= '0;
    end else if (state_q == AAR_LOAD || (state_q == AAR_WAIT && tmr_expire)) begin
      idx_q <= '0;
    end else if (state_q == AAR_SEND && tx_adv) begin
      idx_q <= idx_q + 8'h01;
    end
  end

  // ************************************************************
  // output byte register
  // ************************************************************
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      tx_valid_o <= 1'b0;
      tx_data_o  <= '0;
      tx_first_o <= 1'b0;
      tx_last_o  <= 1'b0;
    end else if (state_q == AAR_SEND && tx_adv) begin
      tx_valid_o <= 1'b1;
      tx_data_o  <= next_byte;
      tx_first_o <= (idx_q == 8'h00);
      tx_last_o  <= is_last;
    end else if (tx_ready_i) begin
      tx_valid_o <= 1'b0;
      tx_first_o <= 1'b0;
      tx_last_o  <= 1'b0;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  wire send_at = (state_q == AAR_SEND) && tx_adv;

  chk_code_byte: assert property (
    (send_at && idx_q == msg_alen_q + OFS_CODE) |=> (tx_data_o == SMS_ASYNC_ALERT)) else $error("bad code byte");
  chk_tag_latch: assert property (
    (state_q == AAR_LOAD) |=> (msg_tag_q == $past(cfg_tag_q))) else $error("tag not from configuration");
  // tag high byte on the wire
  chk_tag_byte: assert property (
    (send_at && idx_q == msg_alen_q + OFS_TAG) |=> (tx_data_o == msg_tag_q[15:8])) else $error("bad tag byte");
  // type byte leads the alert code
  chk_type_byte: assert property (
    (send_at && idx_q == msg_alen_q + OFS_ALERT) |=> (tx_data_o == msg_alert_q[23:16])) else $error("bad type byte");
  chk_ctrl_byte: assert property (
    (send_at && idx_q == msg_alen_q + OFS_CTRL) |=> (tx_data_o == msg_ctrl_q)) else $error("bad control byte");
  chk_chan_byte: assert property (
    (send_at && idx_q == msg_alen_q + OFS_CHAN) |=> (tx_data_o == msg_chan_q[15:8])) else $error("bad channel byte");
  // frame data never above the cap
  chk_data_cap: assert property (
    msg_dlen_q <= LEN_W'(FRAME_DATA_MAX)) else $error("frame data over cap");
  // no frame means no frame data
  chk_no_frame: assert property (
    (push && !alert_has_frame_i) |-> (mem_if.wr_data[ENT_LEN_LSB +: LEN_W] == '0)) else $error("frame data kept");
  // first address byte leads the message
  chk_addr_first: assert property (
    (send_at && idx_q == 8'h00 && msg_alen_q != 8'h00) |=> (tx_data_o == msg_addr_q[0] && tx_first_o))
    else $error("address byte not first");
  chk_tag_match: assert property (
    (pending_q && reply_valid_i && reply_tag_i != msg_tag_q && !flush) |=> pending_q) else $error("wrong tag acked");
  chk_erp_discard: assert property (
    (accept && erp_same && !pop && !flush) |=> (count_q == $past(count_q) && erp_drop_o))
    else $error("recovery exit alert not discarded");
  chk_alert_queued: assert property (
    (push && !pop) |=> (count_q == $past(count_q) + 1'b1)) else $error("alert lost");
  chk_wait_pending: assert property (
    (state_q == AAR_WAIT) |-> pending_q) else $error("waiting without pending alert");
  // expiry starts a resend from byte zero
  chk_retransmit: assert property (
    (state_q == AAR_WAIT && tmr_expire && pending_d) |=> (state_q == AAR_SEND && idx_q == 8'h00))
    else $error("no resend after timeout");
  chk_reset_flush: assert property (
    flush |=> (!pending_q && count_q == '0)) else $error("reset did not flush");
  chk_stray_reply: assert property (
    (reply_valid_i && !pending_q && state_q != AAR_LOAD) |=> (reply_drop_o && !pending_q))
    else $error("stray reply not dropped");
  chk_single_out: assert property (
    pop |-> !pending_q) else $error("second alert outstanding");
  chk_dequeue_only: assert property (
    $rose(pending_q) |-> ($past(state_q) == AAR_LOAD)) else $error("alert sent outside dequeue");
  // all three code bytes stored together
  chk_code_whole: assert property (
    push |-> (mem_if.wr_data[ENT_ALERT_LSB +: ALERT_W] == alert_code_i)) else $error("alert code split");
  // every copy leaving while the alert is still pending rearms the timer
  chk_timer_rearm: assert property (
    (state_q == AAR_DRAIN && tx_ready_i && pending_d) |=> (state_q == AAR_WAIT)) else $error("timer not rearmed");

endmodule

/* File: aar_pkg.sv */
// shared constants and types for the asynchronous alert reporting port
package aar_pkg;

  // ************************************************************
  // message layout
  // ************************************************************
  localparam logic [7:0] SMS_ASYNC_ALERT = 8'h04;   // message code byte
  localparam int         HDR_BYTES       = 11;      // bytes 0..10 before frame data
  localparam int         FRAME_DATA_MAX  = 21;      // cap on copied frame data bytes
  localparam logic [7:0] OFS_CODE        = 8'h00;
  localparam logic [7:0] OFS_PORT        = 8'h01;
  localparam logic [7:0] OFS_TAG         = 8'h02;
  localparam logic [7:0] OFS_ALERT       = 8'h04;
  localparam logic [7:0] OFS_RSVD        = 8'h07;
  localparam logic [7:0] OFS_CTRL        = 8'h08;
  localparam logic [7:0] OFS_CHAN        = 8'h09;
  localparam logic [7:0] RSVD_BYTE       = 8'h00;

  // ************************************************************
  // queue entry layout
  // ************************************************************
  localparam int ALERT_W       = 24;
  localparam int CHAN_W        = 16;
  localparam int LEN_W         = 5;
  localparam int ENT_ALERT_LSB = 0;
  localparam int ENT_CTRL_LSB  = 24;
  localparam int ENT_CHAN_LSB  = 32;
  localparam int ENT_DATA_LSB  = 48;
  localparam int ENT_LEN_LSB   = ENT_DATA_LSB + FRAME_DATA_MAX * 8;
  localparam int ENT_W         = ENT_LEN_LSB + LEN_W;

  // ************************************************************
  // sizes, reset values and timing
  // ************************************************************
  localparam int              QUEUE_DEPTH_DEF = 4;
  localparam int              ADDR_MAX_DEF    = 8;
  localparam logic [15:0]     TAG_RST         = 16'h0000;
  localparam int unsigned     RETRY_MS        = 500;
  localparam int unsigned     CLK_KHZ         = 100_000;
  localparam int unsigned     RETRY_CYCLES    = RETRY_MS * CLK_KHZ;

  // ************************************************************
  // sender states
  // ************************************************************
  typedef enum logic [4:0] {
    AAR_IDLE  = 5'h01,
    AAR_LOAD  = 5'h02,
    AAR_SEND  = 5'h04,
    AAR_DRAIN = 5'h08,
    AAR_WAIT  = 5'h10
  } aar_state_t;

endpackage

/* File: aar_mem_if.sv */
// interface between the alert port and its queue memory
`timescale 1ns/1ps
interface aar_mem_if #(
  parameter int W  = 8,
  parameter int AW = 2
);
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [W-1:0]  wr_data;
  logic          rd_en;
  logic [AW-1:0] rd_addr;
  logic [W-1:0]  rd_data;

  modport mem (input wr_en, input wr_addr, input wr_data, input rd_en, input rd_addr, output rd_data);
  modport ctl (output wr_en, output wr_addr, output wr_data, output rd_en, output rd_addr, input rd_data);
endinterface

/* File: aar_queue_mem.sv */
// alert queue storage with registered read data
`timescale 1ns/1ps
module aar_queue_mem #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  // clock
  input wire logic ref_clk_i,
  // memory port
  aar_mem_if.mem   m
);

  logic [W-1:0] mem_q [DEPTH];

  // write port
  always_ff @(posedge ref_clk_i) begin
    if (m.wr_en) begin
      mem_q[m.wr_addr] <= m.wr_data;
    end
  end

  // read port, data one cycle after the strobe
  always_ff @(posedge ref_clk_i) begin
    if (m.rd_en) begin
      m.rd_data <= mem_q[m.rd_addr];
    end
  end

endmodule

/* File: aar_retry_timer.sv */
// reply timeout counter, one expiry pulse per start
`timescale 1ns/1ps
module aar_retry_timer #(
  parameter int unsigned CYCLES = 4
) (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  // control
  input  wire logic start_i,
  input  wire logic stop_i,
  output logic      expire_o
);

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt_q;
  logic          run_q;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || stop_i) begin
      cnt_q    <= '0;
      run_q    <= 1'b0;
      expire_o <= 1'b0;
    end else if (start_i) begin
      cnt_q    <= CW'(CYCLES - 1);
      run_q    <= 1'b1;
      expire_o <= 1'b0;
    end else if (run_q && cnt_q == '0) begin
      run_q    <= 1'b0;
      expire_o <= 1'b1;
    end else begin
      cnt_q    <= run_q ? cnt_q - 1'b1 : cnt_q;
      expire_o <= 1'b0;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_timer_reload: assert property (
    (start_i && !stop_i) |=> (run_q && cnt_q == CW'(CYCLES - 1))) else $error("timer not reloaded on start");
  chk_expire_end: assert property (
    $rose(expire_o) |-> ($past(run_q) && $past(cnt_q) == '0)) else $error("timer expired early");

endmodule

/* File: aar_master_model.sv */
// far-side master model: takes alert bytes and answers with replies
`timescale 1ns/1ps
module aar_master_model (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  // scenario control
  input  wire logic        slow_i,
  input  wire logic        ans_i,
  input  wire logic        bad_i,
  input  wire logic        poke_i,
  input  wire logic [7:0]  plen_i,
  // byte stream from the port
  input  wire logic        tx_valid_i,
  input  wire logic [7:0]  tx_data_i,
  input  wire logic        tx_last_i,
  output logic             tx_ready_o,
  // replies to the port
  output logic             reply_valid_o,
  output logic [15:0]      reply_tag_o
);
  logic [7:0]  idx_q;
  logic [15:0] tag_q;
  wire         fin = tx_valid_i && tx_ready_o && tx_last_i && ans_i;
  // accept bytes, pick out the tag, reply after each whole copy while ans_i is set
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      idx_q         <= 8'h00;
      tx_ready_o    <= 1'b0;
      reply_valid_o <= 1'b0;
      reply_tag_o   <= 16'h0000;
    end else begin
      tx_ready_o    <= slow_i ? ~tx_ready_o : 1'b1;
      // reply to every copy while ans_i is set, frame fields ignored
      reply_valid_o <= poke_i | fin;
      reply_tag_o   <= fin ? (tag_q ^ {15'h0000, bad_i}) : ~reply_tag_o;
      if (tx_valid_i && tx_ready_o) begin
        idx_q <= tx_last_i ? 8'h00 : idx_q + 8'h01;
        if (idx_q == plen_i + 8'h02) tag_q[15:8] <= tx_data_i;
        if (idx_q == plen_i + 8'h03) tag_q[7:0] <= tx_data_i;
      end
    end
  end
endmodule

/* File: aar_alert_port_tb_top.sv */
// testbench for the alert port with a reference model of its messages
`timescale 1ns/1ps
module aar_alert_port_tb_top;
  import aar_pkg::*;
  logic ref_clk_i = 0, rst_n_i = 0, total_reset_i = 0, absolute_reset_i = 0, cfg_valid_i = 0;
  logic alert_valid_i = 0, alert_has_frame_i = 0, alert_erp_exit_i = 0, tx_ready_i, reply_valid_i;
  logic slow = 0, ans = 1, bad = 0, poke = 0;
  logic [15:0] cfg_tag_i = 16'h0000, alert_chan_i = 16'h0000, reply_tag_i;
  logic [63:0] cfg_path_i = 64'h0;
  logic [23:0] alert_code_i = 24'h0;
  logic [167:0] alert_data_i = 168'h0;
  logic [7:0] cfg_path_len_i = 8'h03, alert_ctrl_i = 8'h00, alert_len_i = 8'h00;
  logic [7:0] alert_src_port_i = 8'h01, alert_tx_port_i = 8'h00, tx_data_o;
  logic alert_ready_o, tx_valid_o, tx_first_o, tx_last_o, pending_o, erp_drop_o, reply_drop_o;
  logic [31:0] seed = 32'h94bb;
  logic [9:0] exp_b[$];
  logic [9:0] nrd = 0, ned = 0;
  int num_errors = 0, checked = 0, i;
  always #5 ref_clk_i = ~ref_clk_i;
  aar_alert_port #(.QUEUE_DEPTH(4), .ADDR_MAX(8), .PORT_NUM(8'h03), .RETRY_CYCLES(20)) dut (
    .ref_clk_i, .rst_n_i, .total_reset_i, .absolute_reset_i, .cfg_valid_i, .cfg_tag_i, .cfg_path_i,
    .cfg_path_len_i, .alert_valid_i, .alert_ready_o, .alert_code_i, .alert_has_frame_i, .alert_ctrl_i,
    .alert_chan_i, .alert_data_i, .alert_len_i, .alert_erp_exit_i, .alert_src_port_i, .alert_tx_port_i,
    .reply_valid_i, .reply_tag_i, .tx_valid_o, .tx_data_o, .tx_first_o, .tx_last_o, .tx_ready_i,
    .pending_o, .erp_drop_o, .reply_drop_o);
  aar_master_model master (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .slow_i(slow), .ans_i(ans),
    .bad_i(bad), .poke_i(poke), .plen_i(cfg_path_len_i), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
    .tx_last_i(tx_last_o), .tx_ready_o(tx_ready_i), .reply_valid_o(reply_valid_i), .reply_tag_o(reply_tag_i));
  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [7:0] rnd8();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic chk(input logic [9:0] g, input logic [9:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  // expected image: path, header, capped frame data
  task automatic push(input int n);
    logic [87:0] h;
    int m, k;
    m = alert_has_frame_i ? (alert_len_i > FRAME_DATA_MAX ? FRAME_DATA_MAX : alert_len_i) : 0;
    h = {SMS_ASYNC_ALERT, 8'h03, cfg_tag_i, alert_code_i, RSVD_BYTE,
         alert_has_frame_i ? {alert_ctrl_i, alert_chan_i} : 24'h0};
    repeat (n) for (k = 0; k < 14 + m; k++) exp_b.push_back({k == 0, k == 13 + m, k < 3 ? cfg_path_i[8*k+:8] :
      k < 14 ? h[8*(13-k)+:8] : alert_data_i[8*(k-14)+:8]});
  endtask
  task automatic put(input logic f, input logic e, input logic [7:0] p, input logic [7:0] n, input int c);
    int k;
    @(posedge ref_clk_i);
    alert_valid_i <= 1;
    alert_has_frame_i <= f;
    alert_erp_exit_i <= e;
    alert_tx_port_i <= p;
    alert_len_i <= n;
    alert_code_i <= {rnd8(), rnd8(), rnd8()};
    alert_ctrl_i <= rnd8();
    alert_chan_i <= {rnd8(), rnd8()};
    for (k = 0; k < 21; k++) alert_data_i[8*k+:8] <= rnd8();
    do @(negedge ref_clk_i); while (alert_ready_o !== 1'b1);
    @(posedge ref_clk_i);
    alert_valid_i <= 0;
    push(c);
  endtask
  task automatic wt(input int n, input bit p);
    int t;
    for (t = 0; t < 3000 && (exp_b.size() > n || (p && pending_o !== 1'b0)); t++) @(negedge ref_clk_i);
    chk(10'(exp_b.size()), 10'(n));
    if (t >= 3000) chk(10'h3ff, 10'h000);
  endtask
  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ************************************************************
  // byte monitor and scenarios
  // ************************************************************
  always @(posedge ref_clk_i) begin
    if (tx_valid_o && tx_ready_i) chk({tx_first_o, tx_last_o, tx_data_o}, exp_b.size() ? exp_b.pop_front() : 10'h3ff);
    if (reply_drop_o) nrd <= nrd + 10'h001;
    if (erp_drop_o) ned <= ned + 10'h001;
  end
  initial begin
    repeat (40000) @(posedge ref_clk_i);
    num_errors++;
    report_and_stop();
  end
  initial begin
    repeat (6) @(posedge ref_clk_i);
    rst_n_i <= 1;
    @(posedge ref_clk_i);
    cfg_valid_i <= 1;
    cfg_tag_i <= {rnd8(), rnd8()};
    for (i = 0; i < 8; i++) cfg_path_i[8*i+:8] <= rnd8();
    @(posedge ref_clk_i);
    cfg_valid_i <= 0;
    put(1, 0, 8'h02, 8'h19, 1);
    wt(0, 1);
    put(0, 0, 8'h02, 8'h05, 1);
    wt(0, 1);
    slow <= 1;
    for (i = 0; i < 4; i++) put(1, 0, 8'h02, 8'(i * 7), 1);
    wt(0, 1);
    slow <= 0;
    put(1, 1, 8'h01, 8'h04, 0);
    put(1, 1, 8'h02, 8'h04, 1);
    wt(0, 1);
    chk(ned, 10'h001);
    bad <= 1;
    put(0, 0, 8'h02, 8'h00, 3);
    wt(28, 0);
    @(posedge ref_clk_i);
    ans <= 0;
    bad <= 0;
    repeat (18) @(negedge ref_clk_i);
    chk(10'(exp_b.size()), 10'd28);
    wt(14, 0);
    chk(pending_o, 10'h001);
    @(posedge ref_clk_i);
    ans <= 1;
    wt(0, 1);
    chk(nrd, 10'h001);
    poke <= 1;
    @(posedge ref_clk_i);
    poke <= 0;
    repeat (3) @(posedge ref_clk_i);
    chk(nrd, 10'h002);
    for (i = 0; i < 2; i++) begin
      ans <= 0;
      put(0, 0, 8'h02, 8'h00, 1);
      repeat (4) put(1, 0, 8'h02, 8'h03, 0);
      wt(0, 0);
      chk(alert_ready_o, 10'h000);
      @(posedge ref_clk_i);
      total_reset_i <= (i == 0);
      absolute_reset_i <= (i == 1);
      @(posedge ref_clk_i);
      total_reset_i <= 0;
      absolute_reset_i <= 0;
      repeat (60) @(negedge ref_clk_i);
      chk(pending_o, 10'h000);
      chk(alert_ready_o, 10'h001);
    end
    report_and_stop();
  end
endmodule
